// *** rtl/adc_trigger.sv ***
`timescale 1ns/1ps

module adc_trigger (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          running,
   input  wire logic                          compl_mode,
   input  wire logic                          up_dir,
   input  wire logic [timer_pkg::COUNT_W-1:0] count,
   input  wire logic [timer_pkg::COUNT_W-1:0] cycle_data,
   input  wire logic [timer_pkg::COUNT_W-1:0] cmp_a,
   input  wire logic [timer_pkg::COUNT_W-1:0] cmp_b,
   input  wire logic [3:0]                    req_en,
   output logic                               req_a,
   output logic                               req_b
);
   import timer_pkg::*;

   logic up_win;
   logic dn_win;
   logic next_req_a;
   logic next_req_b;

   ////////////////////////////////////////////////////////////////////////////
   // windows: the crest value belongs to the falling half, the trough to the rising half
   always_comb begin
      if (compl_mode) begin
         up_win = (up_dir || count == '0) && (count < cycle_data);
         dn_win = (!up_dir || count >= cycle_data) && (count != '0)
                  && (count <= cycle_data);
      end else begin
         up_win = 1'b1;
         dn_win = 1'b0;  // down window is closed here, whatever the down bits hold
      end
      next_req_a = running && (count == cmp_a)
                   && ((req_en[ADC_UP_A] && up_win) || (req_en[ADC_DN_A] && dn_win));
      next_req_b = running && (count == cmp_b)
                   && ((req_en[ADC_UP_B] && up_win) || (req_en[ADC_DN_B] && dn_win));
   end

   // requests are one-cycle pulses, one clock after the matching count value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_a <= 1'b0;
         req_b <= 1'b0;
      end else begin
         req_a <= next_req_a;
         req_b <= next_req_b;
      end
   end

endmodule : adc_trigger

// *** rtl/multifunction_timer.sv ***
`timescale 1ns/1ps

// Summary of operation
// - Clear-time transfer is selectable only in PWM1/PWM2 on channel 0, PWM1 on 3 and 4.
// - Buffer copies to general register at compare match by default, or at counter clearing.
// - With clear-time transfer, rollover from all ones to zero triggers the copy.
// - With clear-time transfer, software writing zero to a running counter triggers the copy.
// - With clear-time transfer, a clear by the selected clear source triggers the copy.
// - A/D start request A or B issues on count equal compare, inside an enabled window.
// - Complementary mode: up enable allows requests while counting up, zero to cycle minus one.
// - Complementary mode: down enable allows requests while counting down, cycle down to one.
// - Outside complementary mode an up enable requests on every match, any direction.
// - Overflow or underflow together with a clear: counter clears, flags stay unchanged.
// - Count step during a counter write: written value is kept, flags are not set.
// - Output level is not reinitialised on mode change, so a high pin may stay high.
module multifunction_timer #(
   parameter int unsigned CHANNEL_ID = 4
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [timer_pkg::DATA_W-1:0] pwdata,
   output logic      [timer_pkg::DATA_W-1:0] prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic                              adc_start_req_a,
   output logic                              adc_start_req_b,
   output logic                              timer_out
);
   import timer_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // elaboration check: only channels 0, 3 and 4 have buffer transfer selection
   if (!(CHANNEL_ID == 0 || CHANNEL_ID == 3 || CHANNEL_ID == 4)) begin : g_bad_channel
      $error("multifunction_timer: CHANNEL_ID must be 0, 3 or 4");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [CTRL_W-1:0]  timer_control;
   logic [COUNT_W-1:0] timer_count;
   logic [COUNT_W-1:0] general_compare_reg;
   logic [COUNT_W-1:0] buffer_reg;
   logic               xfer_at_clear_sel_a;
   logic [COUNT_W-1:0] cycle_data;
   logic [COUNT_W-1:0] adc_compare_a_ch4;
   logic [COUNT_W-1:0] adc_compare_b_ch4;
   logic [3:0]         adc_request_control;
   logic               overflow_flag;
   logic               underflow_flag;
   logic [7:0]         io_ctrl;
   logic               up_dir;

   logic [CTRL_W-1:0]  next_timer_control;
   logic [COUNT_W-1:0] next_timer_count;
   logic [COUNT_W-1:0] next_general_compare_reg;
   logic [COUNT_W-1:0] next_buffer_reg;
   logic               next_xfer_at_clear_sel_a;
   logic [COUNT_W-1:0] next_cycle_data;
   logic [COUNT_W-1:0] next_adc_compare_a_ch4;
   logic [COUNT_W-1:0] next_adc_compare_b_ch4;
   logic [3:0]         next_adc_request_control;
   logic               next_overflow_flag;
   logic               next_underflow_flag;
   logic [7:0]         next_io_ctrl;
   logic               next_up_dir;
   logic               next_timer_out;
   logic [DATA_W-1:0]  next_prdata;
   logic               next_pready;
   logic               next_pslverr;

   // decoded control and events
   timer_mode_t        mode;
   logic               running;
   logic               compl_mode;
   logic               pwm_like;
   logic               xfer_sel_allowed;
   logic               wr;
   logic               wr_count;
   logic               sw_zero;
   logic               cmp_match;
   logic               hw_clear;
   logic               ovf_evt;
   logic               unf_evt;
   logic               clear_event;
   logic               xfer_evt;
   logic [COUNT_W-1:0] step_count;
   logic               step_dir;
   logic [DATA_W-1:0]  rd_mux;
   logic               rd_hit;

   ////////////////////////////////////////////////////////////////////////////
   // mode decode; unused codes behave as normal counting
   always_comb begin
      case (timer_control[CTRL_MODE_MSB:CTRL_MODE_LSB])
         3'h1:    mode = MODE_PWM1;
         3'h2:    mode = MODE_PWM2;
         3'h3:    mode = MODE_COMPL;
         3'h4:    mode = MODE_RSYNC;
         default: mode = MODE_NORMAL;
      endcase
      running    = timer_control[CTRL_START];
      compl_mode = (mode == MODE_COMPL);
      pwm_like   = (mode == MODE_PWM1) || (mode == MODE_PWM2) || (mode == MODE_RSYNC);
      if (CHANNEL_ID == 0) begin
         xfer_sel_allowed = (mode == MODE_PWM1) || (mode == MODE_PWM2);
      end else begin
         xfer_sel_allowed = (mode == MODE_PWM1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // count step: sawtooth up, or triangle between zero and cycle_data
   always_comb begin
      step_count = timer_count;
      step_dir   = up_dir;
      ovf_evt    = 1'b0;
      unf_evt    = 1'b0;
      if (running) begin
         if (compl_mode) begin
            if (up_dir && timer_count >= cycle_data) begin
               step_dir   = 1'b0;
               step_count = timer_count - 16'h0001;
            end else if (up_dir) begin
               step_count = timer_count + 16'h0001;
            end else if (timer_count == '0) begin
               step_dir   = 1'b1;
               step_count = 16'h0001;
               unf_evt    = 1'b1;  // trough turning point
            end else begin
               step_count = timer_count - 16'h0001;
            end
         end else begin
            step_dir   = 1'b1;
            step_count = timer_count + 16'h0001;
            ovf_evt    = (timer_count == 16'hFFFF);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // events; a bus write lands in the access cycle that sees pready high
   always_comb begin
      wr          = psel && penable && pready && pwrite;
      wr_count    = wr && (paddr == OFF_COUNT);
      sw_zero     = wr_count && running && (pwdata[COUNT_W-1:0] == '0);
      cmp_match   = running && (timer_count == general_compare_reg);
      hw_clear    = cmp_match && !compl_mode
                    && (timer_control[CTRL_CLR_MSB:CTRL_CLR_LSB] == CLR_COMPARE);
      clear_event = hw_clear || sw_zero || (ovf_evt && !wr_count);
      if (xfer_at_clear_sel_a && xfer_sel_allowed) begin
         xfer_evt = clear_event;
      end else begin
         xfer_evt = cmp_match;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next register values; hardware events win over a same-cycle bus write, except on the counter and the output pin
   always_comb begin
      next_timer_control       = timer_control;
      next_buffer_reg          = buffer_reg;
      next_xfer_at_clear_sel_a = xfer_at_clear_sel_a;
      next_cycle_data          = cycle_data;
      next_adc_compare_a_ch4   = adc_compare_a_ch4;
      next_adc_compare_b_ch4   = adc_compare_b_ch4;
      next_adc_request_control = adc_request_control;
      next_io_ctrl             = io_ctrl;
      next_general_compare_reg = general_compare_reg;
      next_overflow_flag       = overflow_flag;
      next_underflow_flag      = underflow_flag;
      next_timer_out           = timer_out;
      if (wr) begin
         case (paddr)
            OFF_CONTROL:   next_timer_control       = pwdata[CTRL_W-1:0];
            OFF_GENERAL:   next_general_compare_reg = pwdata[COUNT_W-1:0];
            OFF_BUFFER:    next_buffer_reg          = pwdata[COUNT_W-1:0];
            OFF_XFER_MODE: next_xfer_at_clear_sel_a = pwdata[0];  // stop the counter first
            OFF_CYCLE:     next_cycle_data          = pwdata[COUNT_W-1:0];
            OFF_ADC_CMP_A: next_adc_compare_a_ch4   = pwdata[COUNT_W-1:0];
            OFF_ADC_CMP_B: next_adc_compare_b_ch4   = pwdata[COUNT_W-1:0];
            OFF_ADC_CTRL:  next_adc_request_control = pwdata[3:0];
            OFF_IO_CTRL:   next_io_ctrl             = pwdata[7:0];
            OFF_FLAGS: begin
               if (pwdata[FLAG_OVF]) begin
                  next_overflow_flag = 1'b0;
               end
               if (pwdata[FLAG_UNF]) begin
                  next_underflow_flag = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // copy of the buffer in the very cycle of the event
      if (xfer_evt) begin
         next_general_compare_reg = buffer_reg;
      end
      // flags: set beats clear; suppressed by a clear or a counter write
      if (ovf_evt && !hw_clear && !wr_count) begin
         next_overflow_flag = 1'b1;
      end
      if (unf_evt && !hw_clear && !wr_count) begin
         next_underflow_flag = 1'b1;
      end
      // counter: bus write first, then a clear, then the count step
      next_up_dir = step_dir;
      if (wr_count) begin
         next_timer_count = pwdata[COUNT_W-1:0];
      end else if (hw_clear) begin
         next_timer_count = '0;
      end else begin
         next_timer_count = step_count;
      end
      // output pin; a mode change alone never reloads it, so a high level survives
      if (wr && paddr == OFF_IO_CTRL && pwdata[7:0] == IO_LOW_INIT) begin
         next_timer_out = 1'b0;
      end else if (pwm_like && clear_event) begin
         next_timer_out = 1'b0;
      end else if (pwm_like && cmp_match) begin
         next_timer_out = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb read mux; sampled in the setup cycle so prdata comes from a flop
   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      case (paddr)
         OFF_CONTROL:   rd_mux[CTRL_W-1:0]  = timer_control;
         OFF_COUNT:     rd_mux[COUNT_W-1:0] = timer_count;
         OFF_GENERAL:   rd_mux[COUNT_W-1:0] = general_compare_reg;
         OFF_BUFFER:    rd_mux[COUNT_W-1:0] = buffer_reg;
         OFF_XFER_MODE: rd_mux[0]           = xfer_at_clear_sel_a;
         OFF_CYCLE:     rd_mux[COUNT_W-1:0] = cycle_data;
         OFF_ADC_CMP_A: rd_mux[COUNT_W-1:0] = adc_compare_a_ch4;
         OFF_ADC_CMP_B: rd_mux[COUNT_W-1:0] = adc_compare_b_ch4;
         OFF_ADC_CTRL:  rd_mux[3:0]         = adc_request_control;
         OFF_FLAGS:     rd_mux[1:0]         = {underflow_flag, overflow_flag};
         OFF_IO_CTRL:   rd_mux[7:0]         = io_ctrl;
         default:       rd_hit              = 1'b0;
      endcase
      // no wait state: ready in the first access cycle, never in setup
      next_pready  = psel && !penable;
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (psel && !penable) begin
         next_prdata  = pwrite ? '0 : rd_mux;
         next_pslverr = !rd_hit;
      end else if (!psel) begin
         next_pslverr = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control       <= RST_CONTROL;
         timer_count         <= RST_COUNT;
         general_compare_reg <= RST_REG16;
         buffer_reg          <= RST_REG16;
         xfer_at_clear_sel_a <= RST_XFER;
         cycle_data          <= RST_REG16;
         adc_compare_a_ch4   <= RST_REG16;
         adc_compare_b_ch4   <= RST_REG16;
         adc_request_control <= RST_ADC;
         overflow_flag       <= 1'b0;
         underflow_flag      <= 1'b0;
         io_ctrl             <= RST_IO;
         up_dir              <= 1'b1;
         timer_out           <= 1'b0;
         prdata              <= '0;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
      end else begin
         timer_control       <= next_timer_control;
         timer_count         <= next_timer_count;
         general_compare_reg <= next_general_compare_reg;
         buffer_reg          <= next_buffer_reg;
         xfer_at_clear_sel_a <= next_xfer_at_clear_sel_a;
         cycle_data          <= next_cycle_data;
         adc_compare_a_ch4   <= next_adc_compare_a_ch4;
         adc_compare_b_ch4   <= next_adc_compare_b_ch4;
         adc_request_control <= next_adc_request_control;
         overflow_flag       <= next_overflow_flag;
         underflow_flag      <= next_underflow_flag;
         io_ctrl             <= next_io_ctrl;
         up_dir              <= next_up_dir;
         timer_out           <= next_timer_out;
         prdata              <= next_prdata;
         pready              <= next_pready;
         pslverr             <= next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // a/d start request generation
   adc_trigger u_adc_trigger (
      .pclk       (pclk),
      .presetn    (presetn),
      .running    (running),
      .compl_mode (compl_mode),
      .up_dir     (up_dir),
      .count      (timer_count),
      .cycle_data (cycle_data),
      .cmp_a      (adc_compare_a_ch4),
      .cmp_b      (adc_compare_b_ch4),
      .req_en     (adc_request_control),
      .req_a      (adc_start_req_a),
      .req_b      (adc_start_req_b)
   );

endmodule : multifunction_timer

// *** rtl/timer_pkg.sv ***
package timer_pkg;

   // bus geometry
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned COUNT_W  = 16;

   // register byte offsets
   localparam logic [7:0] OFF_CONTROL    = 8'h00;
   localparam logic [7:0] OFF_COUNT      = 8'h04;
   localparam logic [7:0] OFF_GENERAL    = 8'h08;
   localparam logic [7:0] OFF_BUFFER     = 8'h0C;
   localparam logic [7:0] OFF_XFER_MODE  = 8'h10;
   localparam logic [7:0] OFF_CYCLE      = 8'h14;
   localparam logic [7:0] OFF_ADC_CMP_A  = 8'h18;
   localparam logic [7:0] OFF_ADC_CMP_B  = 8'h1C;
   localparam logic [7:0] OFF_ADC_CTRL   = 8'h20;
   localparam logic [7:0] OFF_FLAGS      = 8'h24;
   localparam logic [7:0] OFF_IO_CTRL    = 8'h28;

   // timer_control fields
   localparam int unsigned CTRL_W        = 7;
   localparam int unsigned CTRL_START    = 0;
   localparam int unsigned CTRL_MODE_LSB = 1;
   localparam int unsigned CTRL_MODE_MSB = 3;
   localparam int unsigned CTRL_CLR_LSB  = 4;
   localparam int unsigned CTRL_CLR_MSB  = 6;

   // count_clear_source encodings
   localparam logic [2:0] CLR_NONE    = 3'h0;
   localparam logic [2:0] CLR_COMPARE = 3'h1;

   // adc_request_control fields
   localparam int unsigned ADC_UP_A = 0;
   localparam int unsigned ADC_UP_B = 1;
   localparam int unsigned ADC_DN_A = 2;
   localparam int unsigned ADC_DN_B = 3;

   // timer_flags fields, write one to clear
   localparam int unsigned FLAG_OVF = 0;
   localparam int unsigned FLAG_UNF = 1;

   // io control value that forces the output pin low
   localparam logic [7:0] IO_LOW_INIT = 8'h11;

   // reset values
   localparam logic [CTRL_W-1:0]  RST_CONTROL = 7'h00;
   localparam logic [COUNT_W-1:0] RST_COUNT   = 16'h0000;
   localparam logic [COUNT_W-1:0] RST_REG16   = 16'hFFFF;
   localparam logic [3:0]         RST_ADC     = 4'h0;
   localparam logic [7:0]         RST_IO      = 8'h00;
   localparam logic               RST_XFER    = 1'b0;

   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_PWM1,
      MODE_PWM2,
      MODE_COMPL,
      MODE_RSYNC
   } timer_mode_t;

endpackage : timer_pkg

// *** verif/adc_pin_partner.sv ***
`timescale 1ns/1ps

module adc_pin_partner (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic req_a,
   input  wire logic req_b,
   output int        n_req_a,
   output int        n_req_b
);
   // the converter starts once per pulse; a stuck request would be counted again on every cycle it stays high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_req_a <= 0;
         n_req_b <= 0;
      end else begin
         if (req_a === 1'b1) n_req_a <= n_req_a + 1;
         if (req_b === 1'b1) n_req_b <= n_req_b + 1;
      end
   end
endmodule : adc_pin_partner

// *** verif/multifunction_timer_buffer_adc_trigger_tb_top.sv ***
`timescale 1ns/1ps

module multifunction_timer_buffer_adc_trigger_tb_top;
   import timer_pkg::*;
   logic               pclk, presetn, psel, penable, pwrite;
   logic [7:0]         paddr;
   logic [DATA_W-1:0]  pwdata, prdata;
   logic               pready, pslverr, req_a, req_b, timer_out;
   int                 n_mismatch, comparisons, cycles, seed, n_req_a, n_req_b;
   logic [31:0]        exp_q[$];
   logic [7:0]         ra[12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h40};
   logic [31:0]        rv[12] = '{32'(RST_CONTROL), 32'(RST_COUNT), 32'(RST_REG16), 32'(RST_REG16), 32'(RST_XFER),
      32'(RST_REG16), 32'(RST_REG16), 32'(RST_REG16), 32'(RST_ADC), 32'h0, 32'(RST_IO), 32'h0};
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;
   multifunction_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adc_start_req_a(req_a), .adc_start_req_b(req_b), .timer_out(timer_out));
   adc_pin_partner u_adc (.pclk(pclk), .presetn(presetn), .req_a(req_a), .req_b(req_b),
      .n_req_a(n_req_a), .n_req_b(n_req_b));
   ////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task complete_run;
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   // a hung handshake would otherwise stall the run forever
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // read data is taken only at the edge where the access completes
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) check(prdata, exp_q.pop_front());
   end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // counter is stopped before the mode write, so the transfer mode never changes mid-count
   task xcase(input logic [31:0] ctrl, xf, gen, cnt, input int n, input logic zwr, take, input logic [31:0] fl);
      logic [31:0] bv;
      bv = {16'h0, 16'($random(seed))};
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_FLAGS, 32'h3);
      wr(OFF_XFER_MODE, xf);
      wr(OFF_GENERAL, gen);
      wr(OFF_BUFFER, bv);
      wr(OFF_COUNT, cnt);
      wr(OFF_CONTROL, ctrl);
      if (zwr) wr(OFF_COUNT, 32'h0);
      repeat (n) @(posedge pclk);
      wr(OFF_CONTROL, 32'h0);
      rd(OFF_GENERAL, take ? bv : gen);
      rd(OFF_FLAGS, fl);
      wr(OFF_IO_CTRL, {24'h0, IO_LOW_INIT});
      repeat (2) @(posedge pclk);
      check(timer_out, 32'h0);
   endtask : xcase
   ////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      seed = 23944; n_mismatch = 0; comparisons = 0; cycles = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++) rd(ra[i], rv[i]);
      xcase(32'h01, 32'h0, 32'h8, 32'h0, 20, 1'b0, 1'b1, 32'h0);
      xcase(32'h03, 32'h1, 32'h8, 32'h0, 20, 1'b0, 1'b0, 32'h0);
      xcase(32'h05, 32'h1, 32'h8, 32'h0, 20, 1'b0, 1'b1, 32'h0);
      xcase(32'h03, 32'h1, 32'h40, 32'hFFF0, 30, 1'b0, 1'b1, 32'h1);
      xcase(32'h03, 32'h1, 32'h8000, 32'h10, 5, 1'b1, 1'b1, 32'h0);
      xcase(32'h13, 32'h1, 32'h8, 32'h0, 20, 1'b0, 1'b1, 32'h0);
      xcase(32'h11, 32'h0, 32'hFFFF, 32'hFFF8, 20, 1'b0, 1'b1, 32'h0);
      // zero write lands exactly on the FFFF step, so the overflow must stay unset
      xcase(32'h01, 32'h0, 32'h8, 32'hFFFD, 20, 1'b1, 1'b1, 32'h0);
      xcase(32'h09, 32'h1, 32'h8, 32'h0, 20, 1'b0, 1'b1, 32'h0);
      // pwm1 drives the pin high; leaving the mode must not reload it
      wr(OFF_GENERAL, 32'h4);
      wr(OFF_COUNT, 32'h0);
      wr(OFF_CONTROL, 32'h03);
      repeat (8) @(posedge pclk);
      wr(OFF_CONTROL, 32'h0); // back to normal first
      check(timer_out, 32'h1);
      wr(OFF_IO_CTRL, {24'h0, IO_LOW_INIT});
      wr(OFF_COUNT, 32'h0);
      wr(OFF_CONTROL, 32'h08);
      check(timer_out, 32'h0);
      wr(OFF_CONTROL, 32'h09); // restart comes last
      wr(OFF_CONTROL, 32'h0);
      // normal mode: up enable only, down enables kept clear
      wr(OFF_ADC_CMP_A, 32'h5);
      wr(OFF_ADC_CMP_B, 32'h5);
      wr(OFF_ADC_CTRL, 32'h1);
      wr(OFF_COUNT, 32'h0);
      wr(OFF_CONTROL, 32'h01);
      repeat (20) @(posedge pclk);
      wr(OFF_CONTROL, 32'h0);
      check(n_req_a, 32'h1);
      check(n_req_b, 32'h0);
      // complementary: A sits on the crest, outside the up window; B hit once on the way down
      wr(OFF_CYCLE, 32'h10);
      wr(OFF_ADC_CMP_A, 32'h10);
      wr(OFF_ADC_CMP_B, 32'hF);
      wr(OFF_ADC_CTRL, 32'h9);
      wr(OFF_COUNT, 32'h0);
      wr(OFF_CONTROL, 32'h07);
      repeat (25) @(posedge pclk);
      wr(OFF_CONTROL, 32'h0);
      check(n_req_a, 32'h1);
      check(n_req_b, 32'h1);
      repeat (3) @(posedge pclk);
      complete_run();
   end
endmodule : multifunction_timer_buffer_adc_trigger_tb_top

// *** verif/timer_port_checker.sv ***
`timescale 1ns/1ps

module timer_port_checker (
   input wire logic                         pclk,
   input wire logic                         presetn,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [7:0]                   paddr,
   input wire logic [timer_pkg::DATA_W-1:0] pwdata,
   input wire logic [timer_pkg::DATA_W-1:0] prdata,
   input wire logic                         pready,
   input wire logic                         pslverr,
   input wire logic                         adc_start_req_a,
   input wire logic                         adc_start_req_b,
   input wire logic                         timer_out
);
   import timer_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // anything past the last word or off word alignment must be refused
   logic bad_addr;
   assign bad_addr = (paddr > OFF_IO_CTRL) || (paddr[1:0] != 2'h0);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_io_low_wr;
      psel && penable && pready && pwrite && paddr == OFF_IO_CTRL && pwdata[7:0] == IO_LOW_INIT;
   endsequence
   ////////////////////////////////////////////////////////////////
   a_ready_setup: assert property (s_setup |=> pready) else $error("no answer after setup");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
   a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
   a_err_unmapped: assert property (s_setup ##0 bad_addr |=> pslverr) else $error("unmapped not refused");
   a_err_mapped: assert property (s_setup ##0 !bad_addr |=> !pslverr) else $error("mapped refused");
   a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == '0) else $error("refused read not 0");
   a_req_a_pulse: assert property (adc_start_req_a |=> !adc_start_req_a) else $error("req a too long");
   a_req_b_pulse: assert property (adc_start_req_b |=> !adc_start_req_b) else $error("req b too long");
   a_io_low_now: assert property (s_io_low_wr |-> ##[1:2] !timer_out) else $error("pin not forced low");
endmodule : timer_port_checker

bind multifunction_timer timer_port_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .adc_start_req_a(adc_start_req_a), .adc_start_req_b(adc_start_req_b), .timer_out(timer_out));
